// >>> usart_cfg_pkg.sv
// Package with register map, field layout and reset values of the serial port config slice
// Operation
// R1: Character length code selects 5 to 9 bits
// R2: Character length write applies at once, no busy
// R3: Rate value is 16 bits, reset zero
// R4: Fractional mode: bits 15:13 fraction, 12:0 integer
// R5: Rate write only when disabled and unlocked
// R6: Infrared pulse kept if length at least value+1
// R7: Enable clear: one clears enable, zero keeps
// R8: Enable set: one sets enable, zero keeps
// R9: Set and clear views share one enable
// R10: Enable bit positions, bit six unused
// R11: Source requests only while its enable is one
// R12: Enables and pulse length reset to zero
// R13: Encode select zero plain, one infrared
// R14: Error source is OR of five errors
// R15: Interrupt is OR of flags and enables
package usart_cfg_pkg;
   // ----------------
   // Register indices, byte address is four times the index
   // ----------------
   localparam logic [5:0] IDX_CTRL     = 6'h00;
   localparam logic [5:0] IDX_RATE     = 6'h0C;
   localparam logic [5:0] IDX_MIN_PULSE = 6'h0E;
   localparam logic [5:0] IDX_IE_CLEAR = 6'h14;
   localparam logic [5:0] IDX_IE_SET   = 6'h16;
   localparam logic [5:0] IDX_STATUS   = 6'h1E;
   localparam logic [5:0] IDX_RX_DATA  = 6'h28;

   // ----------------
   // Control register fields
   // ----------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SAMPLE_BIT = 1;
   localparam int CTRL_ENCODE_BIT = 2;
   localparam int CTRL_CHLEN_LSB  = 4;
   localparam int CTRL_W          = 7;

   // ----------------
   // Character length codes and data widths
   // ----------------
   localparam logic [2:0] CHLEN_8 = 3'h0;
   localparam logic [2:0] CHLEN_9 = 3'h1;
   localparam logic [2:0] CHLEN_5 = 3'h5;
   localparam logic [2:0] CHLEN_6 = 3'h6;
   localparam logic [2:0] CHLEN_7 = 3'h7;
   localparam int CHAR_W = 9;

   // ----------------
   // Rate value layout
   // ----------------
   localparam int RATE_W      = 16;
   localparam int FRAC_LSB    = 13;
   localparam int FRAC_W      = 3;
   localparam int RATE_INT_W  = 13;

   // ----------------
   // Interrupt enable bit positions
   // ----------------
   localparam int IE_TX_EMPTY = 0;
   localparam int IE_TX_DONE  = 1;
   localparam int IE_RX_DONE  = 2;
   localparam int IE_RX_START = 3;
   localparam int IE_CTS      = 4;
   localparam int IE_RX_BREAK = 5;
   localparam int IE_ERROR    = 7;
   localparam logic [7:0] IE_USED_MASK = 8'hBF;
   localparam int N_ERR = 5;

   // ----------------
   // Reset values
   // ----------------
   localparam logic [CTRL_W-1:0] CTRL_RST  = 7'h00;
   localparam logic [15:0]       RATE_RST  = 16'h0000;
   localparam logic [7:0]        PULSE_RST = 8'h00;
   localparam logic [7:0]        IE_RST    = 8'h00;

   // ----------------
   // Bus responses
   // ----------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> usart_rx_buffer.sv
// Two-entry buffer between the receiver and the bus data read
`timescale 1ns/100ps
module usart_rx_buffer
   import usart_cfg_pkg::*;
#(
   parameter int WIDTH = CHAR_W,
   parameter int DEPTH = 2
)
(
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_b,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [1:0]       count_reg;
   logic [1:0]       count_next;
   logic             ready_reg;
   logic             ready_next;
   logic             valid_reg;
   logic             valid_next;
   logic             push;
   logic             pop;

   always_comb
   begin
      push       = i_valid & ready_reg;
      pop        = i_ready & valid_reg;
      mem_next   = mem_reg;
      count_next = count_reg;
      if (pop)
      begin
         mem_next[0] = mem_reg[1];
         count_next  = count_reg - 2'd1;
      end
      if (push)
      begin
         mem_next[count_next[0]] = i_data;
         count_next              = count_next + 2'd1;
      end
      // Ready comes from a flop so a full buffer stalls the source cleanly
      ready_next = (count_next != 2'(DEPTH));
      valid_next = (count_next != 2'd0);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         mem_reg   <= '{default: '0};
         count_reg <= 2'd0;
         ready_reg <= 1'b1;
         valid_reg <= 1'b0;
      end
      else
      begin
         mem_reg   <= mem_next;
         count_reg <= count_next;
         ready_reg <= ready_next;
         valid_reg <= valid_next;
      end
   end

   assign o_ready = ready_reg;
   assign o_valid = valid_reg;
   assign o_data  = mem_reg[0];
endmodule

// >>> usart_ir_filter.sv
// Receive line filter that drops infrared pulses no longer than the minimum length value
`timescale 1ns/100ps
module usart_ir_filter
   import usart_cfg_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_line,
   input  wire logic       i_ir_sel,
   input  wire logic [7:0] i_min_len,
   output logic            o_line,
   output logic            o_pulse_ok
);
   logic [8:0] low_cnt_reg;
   logic [8:0] low_cnt_next;
   logic       line_reg;
   logic       line_next;
   logic       ok_reg;
   logic       ok_next;
   logic       hit;

   always_comb
   begin
      // The core clock is the serial engine clock, so one count is one period
      hit          = !i_line && (low_cnt_reg == {1'b0, i_min_len}); // R6
      low_cnt_next = low_cnt_reg;
      if (i_line)
         low_cnt_next = 9'h000;
      else if (low_cnt_reg != 9'h1FF)
         low_cnt_next = low_cnt_reg + 9'h001;
      ok_next   = i_ir_sel && hit;
      line_next = i_ir_sel ? !hit : i_line; // R13
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         low_cnt_reg <= 9'h000;
         line_reg    <= 1'b1;
         ok_reg      <= 1'b0;
      end
      else
      begin
         low_cnt_reg <= low_cnt_next;
         line_reg    <= line_next;
         ok_reg      <= ok_next;
      end
   end

   assign o_line     = line_reg;
   assign o_pulse_ok = ok_reg;
endmodule

// >>> usart_cfg_regs.sv
// Serial port configuration and interrupt enable registers behind an AXI4-Lite slave
`timescale 1ns/100ps
module usart_cfg_regs
   import usart_cfg_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_b,
   // AXI4-Lite slave
   input  wire logic [7:0]        i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic      [1:0]        o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [7:0]        i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic      [31:0]       o_rdata,
   output logic      [1:0]        o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   // Access controller lock
   input  wire logic              i_wr_lock,
   // Serial engine side
   input  wire logic [5:0]        i_src_flags,
   input  wire logic [N_ERR-1:0]  i_err_flags,
   input  wire logic              i_rx_line,
   input  wire logic [CHAR_W-1:0] i_rx_data,
   input  wire logic              i_rx_valid,
   output logic                   o_rx_ready,
   output logic                   o_enable,
   output logic      [3:0]        o_char_bits,
   output logic      [RATE_W-1:0] o_rate_int,
   output logic      [FRAC_W-1:0] o_frac_part,
   output logic                   o_encode_sel,
   output logic                   o_rx_line,
   output logic                   o_ir_pulse_ok,
   output logic      [7:0]        o_irq_mask,
   output logic                   o_irq
);
   // ----------------
   // Declarations
   // ----------------
   logic                aw_have_reg;
   logic                aw_have_next;
   logic [5:0]          waddr_reg;
   logic [5:0]          waddr_next;
   logic                w_have_reg;
   logic                w_have_next;
   logic [31:0]         wdata_reg;
   logic [31:0]         wdata_next;
   logic [3:0]          wstrb_reg;
   logic [3:0]          wstrb_next;
   logic                awready_reg;
   logic                awready_next;
   logic                wready_reg;
   logic                wready_next;
   logic                bvalid_reg;
   logic                bvalid_next;
   logic [1:0]          bresp_reg;
   logic [1:0]          bresp_next;
   logic                do_wr;

   logic                arready_reg;
   logic                arready_next;
   logic                rvalid_reg;
   logic                rvalid_next;
   logic [31:0]         rdata_reg;
   logic [31:0]         rdata_next;
   logic [1:0]          rresp_reg;
   logic [1:0]          rresp_next;
   logic                ar_take;
   logic                rx_pop;

   logic [CTRL_W-1:0]   ctrl_reg;
   logic [CTRL_W-1:0]   ctrl_next;
   logic [RATE_W-1:0]   rate_reg;
   logic [RATE_W-1:0]   rate_next;
   logic [7:0]          pulse_reg;
   logic [7:0]          pulse_next;
   logic [7:0]          ie_reg;
   logic [7:0]          ie_next;

   logic [3:0]          char_bits_reg;
   logic [3:0]          char_bits_next;
   logic [RATE_W-1:0]   rate_int_reg;
   logic [RATE_W-1:0]   rate_int_next;
   logic [FRAC_W-1:0]   frac_reg;
   logic [FRAC_W-1:0]   frac_next;
   logic                irq_reg;
   logic                irq_next;
   logic [7:0]          src_vec;
   logic [7:0]          pending;

   logic [CHAR_W-1:0]   buf_data;
   logic                buf_valid;
   logic                enabled;
   logic [2:0]          chlen;

   assign enabled = ctrl_reg[CTRL_ENABLE_BIT];
   assign chlen   = ctrl_reg[CTRL_CHLEN_LSB +: 3];

   // ----------------
   // Write channels: address and data taken in either order
   // ----------------
   always_comb
   begin
      do_wr        = aw_have_reg && w_have_reg && !bvalid_reg;
      aw_have_next = aw_have_reg;
      waddr_next   = waddr_reg;
      w_have_next  = w_have_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      if (do_wr)
      begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
      end
      else
      begin
         if (i_awvalid && awready_reg)
         begin
            aw_have_next = 1'b1;
            waddr_next   = i_awaddr[7:2];
         end
         if (i_wvalid && wready_reg)
         begin
            w_have_next = 1'b1;
            wdata_next  = i_wdata;
            wstrb_next  = i_wstrb;
         end
      end
      awready_next = !aw_have_next;
      wready_next  = !w_have_next;
      bvalid_next  = bvalid_reg && !i_bready;
      bresp_next   = bresp_reg;
      if (do_wr)
      begin
         bvalid_next = 1'b1;
         unique case (waddr_reg)
            IDX_CTRL, IDX_MIN_PULSE, IDX_IE_CLEAR, IDX_IE_SET:
               bresp_next = i_wr_lock ? RESP_SLVERR : RESP_OKAY;
            IDX_RATE:
               bresp_next = (i_wr_lock || enabled) ? RESP_SLVERR : RESP_OKAY; // R5
            IDX_STATUS, IDX_RX_DATA:
               bresp_next = RESP_OKAY;
            default:
               bresp_next = RESP_DECERR;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         aw_have_reg <= 1'b0;
         waddr_reg   <= 6'h00;
         w_have_reg  <= 1'b0;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end
      else
      begin
         aw_have_reg <= aw_have_next;
         waddr_reg   <= waddr_next;
         w_have_reg  <= w_have_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
      end
   end

   // ----------------
   // Configuration registers
   // ----------------
   always_comb
   begin
      ctrl_next  = ctrl_reg;
      rate_next  = rate_reg;
      pulse_next = pulse_reg;
      ie_next    = ie_reg;
      if (do_wr && !i_wr_lock && wstrb_reg[0])
      begin
         unique case (waddr_reg)
            // Takes effect on the next edge, there is no busy handshake
            IDX_CTRL:      ctrl_next  = wdata_reg[CTRL_W-1:0]; // R2
            IDX_MIN_PULSE: pulse_next = wdata_reg[7:0];
            IDX_IE_CLEAR:  ie_next    = ie_reg & ~wdata_reg[7:0]; // R7 R9
            IDX_IE_SET:    ie_next    = ie_reg | (wdata_reg[7:0] & IE_USED_MASK); // R8 R9 R10
            default:       ie_next    = ie_reg;
         endcase
      end
      if (do_wr && !i_wr_lock && !enabled && waddr_reg == IDX_RATE) // R5
      begin
         if (wstrb_reg[0])
            rate_next[7:0] = wdata_reg[7:0];
         if (wstrb_reg[1])
            rate_next[15:8] = wdata_reg[15:8];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_reg  <= CTRL_RST;
         rate_reg  <= RATE_RST; // R3
         pulse_reg <= PULSE_RST; // R12
         ie_reg    <= IE_RST; // R12
      end
      else
      begin
         ctrl_reg  <= ctrl_next;
         rate_reg  <= rate_next;
         pulse_reg <= pulse_next;
         ie_reg    <= ie_next;
      end
   end

   // ----------------
   // Read channel
   // ----------------
   always_comb
   begin
      ar_take     = i_arvalid && arready_reg;
      rx_pop      = ar_take && (i_araddr[7:2] == IDX_RX_DATA) && buf_valid;
      rvalid_next = rvalid_reg && !i_rready;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (ar_take)
      begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         unique case (i_araddr[7:2])
            IDX_CTRL:      rdata_next = {25'h0, ctrl_reg};
            IDX_RATE:      rdata_next = {16'h0000, rate_reg};
            IDX_MIN_PULSE: rdata_next = {24'h00_0000, pulse_reg};
            IDX_IE_CLEAR,
            IDX_IE_SET:    rdata_next = {24'h00_0000, ie_reg}; // R9
            IDX_STATUS:    rdata_next = {23'h00_0000, irq_reg, pending};
            IDX_RX_DATA:   rdata_next = {22'h00_0000, buf_valid, buf_data};
            default:
            begin
               rdata_next = 32'h0000_0000;
               rresp_next = RESP_DECERR;
            end
         endcase
      end
      arready_next = !rvalid_next;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= RESP_OKAY;
      end
      else
      begin
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   // ----------------
   // Decoded settings and interrupt request
   // ----------------
   always_comb
   begin
      src_vec              = {2'b00, i_src_flags};
      src_vec[IE_ERROR]    = |i_err_flags; // R14
      pending              = src_vec & ie_reg; // R11
      irq_next             = |pending; // R15
      // Reserved codes fall back to eight bits rather than an odd width
      unique case (chlen) // R1
         CHLEN_8: char_bits_next = 4'd8;
         CHLEN_9: char_bits_next = 4'd9;
         CHLEN_5: char_bits_next = 4'd5;
         CHLEN_6: char_bits_next = 4'd6;
         CHLEN_7: char_bits_next = 4'd7;
         default: char_bits_next = 4'd8;
      endcase
      if (ctrl_reg[CTRL_SAMPLE_BIT]) // R4
      begin
         rate_int_next = {3'b000, rate_reg[RATE_INT_W-1:0]};
         frac_next     = rate_reg[FRAC_LSB +: FRAC_W];
      end
      else
      begin
         rate_int_next = rate_reg; // R3
         frac_next     = 3'h0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         char_bits_reg <= 4'd8;
         rate_int_reg  <= RATE_RST;
         frac_reg      <= 3'h0;
         irq_reg       <= 1'b0;
      end
      else
      begin
         char_bits_reg <= char_bits_next;
         rate_int_reg  <= rate_int_next;
         frac_reg      <= frac_next;
         irq_reg       <= irq_next;
      end
   end

   // ----------------
   // Receive path: line filter and character buffer
   // ----------------
   usart_ir_filter u_filter
   (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_line     (i_rx_line),
      .i_ir_sel   (ctrl_reg[CTRL_ENCODE_BIT]),
      .i_min_len  (pulse_reg),
      .o_line     (o_rx_line),
      .o_pulse_ok (o_ir_pulse_ok)
   );

   usart_rx_buffer #(.WIDTH(CHAR_W), .DEPTH(2)) u_rx_buf
   (
      .i_core_clk (i_core_clk),
      .i_rst_b    (i_rst_b),
      .i_data     (i_rx_data),
      .i_valid    (i_rx_valid),
      .o_ready    (o_rx_ready),
      .o_data     (buf_data),
      .o_valid    (buf_valid),
      .i_ready    (rx_pop)
   );

   assign o_awready    = awready_reg;
   assign o_wready     = wready_reg;
   assign o_bvalid     = bvalid_reg;
   assign o_bresp      = bresp_reg;
   assign o_arready    = arready_reg;
   assign o_rvalid     = rvalid_reg;
   assign o_rdata      = rdata_reg;
   assign o_rresp      = rresp_reg;
   assign o_enable     = ctrl_reg[CTRL_ENABLE_BIT];
   assign o_encode_sel = ctrl_reg[CTRL_ENCODE_BIT];
   assign o_char_bits  = char_bits_reg;
   assign o_rate_int   = rate_int_reg;
   assign o_frac_part  = frac_reg;
   assign o_irq_mask   = ie_reg;
   assign o_irq        = irq_reg;
endmodule

// >>> usart_cfg_asserts.sv
// Port relations checker for the serial port config slice
`timescale 1ns/100ps
module usart_cfg_asserts
   import usart_cfg_pkg::*;
(
   input wire logic              i_core_clk,
   input wire logic              i_rst_b,
   input wire logic              i_arvalid,
   input wire logic              o_arready,
   input wire logic              o_rvalid,
   input wire logic              i_rready,
   input wire logic [31:0]       o_rdata,
   input wire logic              o_bvalid,
   input wire logic              i_bready,
   input wire logic [1:0]        o_bresp,
   input wire logic [5:0]        i_src_flags,
   input wire logic [N_ERR-1:0]  i_err_flags,
   input wire logic [7:0]        o_irq_mask,
   input wire logic              o_irq,
   input wire logic [3:0]        o_char_bits,
   input wire logic [RATE_W-1:0] o_rate_int,
   input wire logic [FRAC_W-1:0] o_frac_part,
   input wire logic              i_rx_line,
   input wire logic              o_rx_line,
   input wire logic              o_encode_sel,
   input wire logic              o_ir_pulse_ok
);
   // ----------------
   // Checks
   // ----------------
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_ar_taken; i_arvalid && o_arready; endsequence
   sequence s_r_wait; o_rvalid && !i_rready; endsequence
   a_read_answer: assert property (s_ar_taken |=> o_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_r_wait |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   a_irq_or: assert property (o_irq == |({|$past(i_err_flags), 1'b0,
      $past(i_src_flags)} & $past(o_irq_mask))) else $error("irq mismatch");
   a_mask_gap: assert property (!o_irq_mask[6])
      else $error("unused enable set");
   a_char_legal: assert property (o_char_bits inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9})
      else $error("bad char length");
   a_frac_int: assert property (o_frac_part != 3'h0 |-> o_rate_int[15:13] == 3'h0)
      else $error("integer part too wide");
   a_plain_line: assert property (!o_encode_sel && $past(!o_encode_sel)
      |-> o_rx_line == $past(i_rx_line)) else $error("plain line not passed");
   a_ir_line: assert property (o_encode_sel && $past(o_encode_sel)
      |-> o_rx_line == !o_ir_pulse_ok) else $error("infrared line wrong");
   a_ir_single: assert property (o_ir_pulse_ok |=> !o_ir_pulse_ok)
      else $error("pulse accept too long");
endmodule

// >>> usart_line_partner.sv
// Far-side model: receive line and received characters
`timescale 1ns/100ps
module usart_line_partner
   import usart_cfg_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_rx_ready,
   output logic                   o_rx_line,
   output logic      [CHAR_W-1:0] o_rx_data,
   output logic                   o_rx_valid
);
   // ----------------
   // Line and data
   // ----------------
   initial
   begin
      o_rx_line = 1'b1;
      o_rx_data = '0;
      o_rx_valid = 1'b0;
   end
   // Low run of len cycles; line idles high as with a pull-up
   task automatic pulse(input int len);
      @(posedge i_core_clk);
      o_rx_line <= 1'b0;
      repeat (len) @(posedge i_core_clk);
      o_rx_line <= 1'b1;
   endtask
   // Inverse shown after hand-off so stale data never looks valid
   task automatic send(input logic [CHAR_W-1:0] ch);
      int n;
      @(posedge i_core_clk);
      o_rx_data <= ch;
      o_rx_valid <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_core_clk);
         if (i_rx_ready)
            break;
      end
      o_rx_valid <= 1'b0;
      o_rx_data <= ~ch;
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the serial port config slice
`timescale 1ns/100ps
module testbench
   import usart_cfg_pkg::*;
;
   logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
   logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_wr_lock = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_irq_mask;
   logic [31:0] i_wdata = 32'h0000_0000, o_rdata, miscompares = 0, samples_checked = 0;
   logic [3:0] i_wstrb = 4'hF, o_char_bits;
   logic [5:0] i_src_flags = 6'h00;
   logic [N_ERR-1:0] i_err_flags = '0;
   logic [CHAR_W-1:0] i_rx_data;
   logic i_rx_line, i_rx_valid, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_rx_ready, o_enable, o_encode_sel, o_rx_line, o_ir_pulse_ok, o_irq;
   logic [1:0] o_bresp, o_rresp, bq[$];
   logic [RATE_W-1:0] o_rate_int;
   logic [FRAC_W-1:0] o_frac_part;
   logic [33:0] rq[$];
   logic [31:0] pulses = 0;
   usart_cfg_regs i_usart_cfg_regs (.*);
   usart_line_partner i_usart_line_partner (.i_core_clk, .i_rx_ready(o_rx_ready),
      .o_rx_line(i_rx_line), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid));
   initial forever #10 i_core_clk = ~i_core_clk;
   // ----------------
   // Tasks
   // ----------------
   task automatic close_out();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic limit(input int n);
      if (n < 40)
         return;
      miscompares++;
      close_out();
   endtask
   task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge i_core_clk);
      bq.push_back(r);
      i_awaddr <= {a, 2'b00};
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_core_clk);
         if (i_awvalid && o_awready)
            i_awvalid <= 1'b0;
         if (i_wvalid && o_wready)
            i_wvalid <= 1'b0;
         if (o_bvalid)
            break;
      end
      i_bready <= 1'b0;
      limit(n);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge i_core_clk);
      rq.push_back({r, d});
      i_araddr <= {a, 2'b00};
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge i_core_clk);
         if (i_arvalid && o_arready)
            i_arvalid <= 1'b0;
         if (o_rvalid)
            break;
      end
      i_rready <= 1'b0;
      limit(n);
   endtask
   always @(posedge i_core_clk)
   begin
      if (o_rvalid && i_rready)
         cmp("read", rq.pop_front(), {o_rresp, o_rdata});
      if (o_bvalid && i_bready)
         cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, o_bresp});
      if (o_ir_pulse_ok)
         pulses <= pulses + 1;
   end
   // ----------------
   // Scenarios
   // ----------------
   initial
   begin
      logic [2:0] cl[5] = '{CHLEN_8, CHLEN_9, CHLEN_5, CHLEN_6, CHLEN_7};
      logic [3:0] cw[5] = '{4'h8, 4'h9, 4'h5, 4'h6, 4'h7};
      logic [15:0] rv;
      logic [7:0] m, p;
      void'($urandom(96));
      repeat (8) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      rd(IDX_RATE, 32'h0, RESP_OKAY);
      rd(IDX_MIN_PULSE, 32'h0, RESP_OKAY);
      rd(IDX_IE_SET, 32'h0, RESP_OKAY);
      rd(6'h3F, 32'h0, RESP_DECERR);
      wr(6'h3F, 32'h0, RESP_DECERR);
      foreach (cl[i])
      begin
         wr(IDX_CTRL, {25'h0, cl[i], 4'h0}, RESP_OKAY);
         @(negedge i_core_clk);
         cmp("char bits", {30'h0, cw[i]}, {30'h0, o_char_bits});
      end
      rv = 16'($urandom);
      wr(IDX_RATE, {16'h0, rv}, RESP_OKAY);
      @(negedge i_core_clk);
      cmp("rate", {18'h0, rv}, {18'h0, o_rate_int});
      wr(IDX_CTRL, 32'h0000_0002, RESP_OKAY);
      @(negedge i_core_clk);
      cmp("frac", {31'h0, rv[15:13]}, {31'h0, o_frac_part});
      cmp("integer", {21'h0, rv[12:0]}, {18'h0, o_rate_int});
      wr(IDX_CTRL, 32'h0000_0001, RESP_OKAY);
      cmp("enable", 34'h1, {33'h0, o_enable});
      wr(IDX_RATE, {16'h0, ~rv}, RESP_SLVERR);
      wr(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
      i_wr_lock <= 1'b1;
      wr(IDX_RATE, {16'h0, ~rv}, RESP_SLVERR);
      i_wr_lock <= 1'b0;
      rd(IDX_RATE, {16'h0, rv}, RESP_OKAY);
      wr(IDX_IE_SET, 32'h0000_00FF, RESP_OKAY);
      rd(IDX_IE_CLEAR, 32'h0000_00BF, RESP_OKAY);
      wr(IDX_IE_CLEAR, 32'h0000_0005, RESP_OKAY);
      wr(IDX_IE_SET, 32'h0, RESP_OKAY);
      wr(IDX_IE_CLEAR, 32'h0, RESP_OKAY);
      rd(IDX_IE_SET, 32'h0000_00BA, RESP_OKAY);
      for (int i = 0; i < 6; i++)
      begin
         m = 8'($urandom) & IE_USED_MASK;
         wr(IDX_IE_CLEAR, 32'h0000_00FF, RESP_OKAY);
         wr(IDX_IE_SET, {24'h0, m}, RESP_OKAY);
         i_src_flags <= 6'($urandom);
         i_err_flags <= i[0] ? 5'($urandom) : 5'h00;
         repeat (2) @(posedge i_core_clk);
         @(negedge i_core_clk);
         p = {|i_err_flags, 1'b0, i_src_flags} & m;
         cmp("irq", {33'h0, |p}, {33'h0, o_irq});
         rd(IDX_STATUS, {23'h0, |p, p}, RESP_OKAY);
      end
      wr(IDX_MIN_PULSE, 32'h0000_0003, RESP_OKAY);
      wr(IDX_CTRL, 32'h0000_0004, RESP_OKAY);
      repeat (2) @(posedge i_core_clk);
      i_usart_line_partner.pulse(3);
      repeat (6) @(posedge i_core_clk);
      cmp("short pulse", 34'h0, {2'h0, pulses});
      i_usart_line_partner.pulse(4);
      repeat (6) @(posedge i_core_clk);
      cmp("long pulse", 34'h1, {2'h0, pulses});
      i_usart_line_partner.send(9'h1A5);
      i_usart_line_partner.send(9'h0C3);
      @(negedge i_core_clk);
      cmp("rx full", 34'h0, {33'h0, o_rx_ready});
      rd(IDX_RX_DATA, 32'h0000_03A5, RESP_OKAY);
      rd(IDX_RX_DATA, 32'h0000_02C3, RESP_OKAY);
      @(negedge i_core_clk);
      cmp("rx free", 34'h1, {33'h0, o_rx_ready});
      close_out();
   end
endmodule
bind usart_cfg_regs usart_cfg_asserts i_usart_cfg_asserts (.*);
